// ---- adc_map_pkg.sv ----
package adc_map_pkg;

	// Frame geometry
	localparam int NUM_CH = 4;
	localparam int SMP_PER_CH = 8;
	localparam int SMP_W = 12;
	localparam int NUM_LANES = 8;
	localparam int LANE_OCTETS = 5;
	localparam int OCT_W = 8;
	localparam int NIB_W = 4;
	localparam int LANE_W = LANE_OCTETS * OCT_W;
	localparam int W8 = 8;
	localparam int W10 = 10;

	// Supported link mode codes
	localparam logic [3:0] MODE_2 = 4'h2;
	localparam logic [3:0] MODE_3 = 4'h3;
	localparam logic [3:0] MODE_4 = 4'h4;
	localparam logic [3:0] MODE_5 = 4'h5;
	localparam logic [3:0] MODE_6 = 4'h6;
	localparam logic [3:0] MODE_7 = 4'h7;
	localparam logic [3:0] MODE_8 = 4'h8;
	localparam logic [3:0] MODE_9 = 4'h9;
	localparam logic [3:0] MODE_10 = 4'hA;
	localparam logic [3:0] MODE_RST = 4'h2;

	// Octets per lane frame
	localparam logic [2:0] OCT_1 = 3'h1;
	localparam logic [2:0] OCT_2 = 3'h2;
	localparam logic [2:0] OCT_3 = 3'h3;
	localparam logic [2:0] OCT_5 = 3'h5;

	// Lane enable masks by lane count
	localparam logic [7:0] LANES_0 = 8'h00;
	localparam logic [7:0] LANES_1 = 8'h01;
	localparam logic [7:0] LANES_2 = 8'h03;
	localparam logic [7:0] LANES_3 = 8'h07;
	localparam logic [7:0] LANES_4 = 8'h0F;
	localparam logic [7:0] LANES_6 = 8'h3F;
	localparam logic [7:0] LANES_8 = 8'hFF;

	// Padding for absent channels
	localparam logic [3:0] PAD_NIBBLE = 4'h0;
	localparam logic [7:0] PAD_OCTET = 8'h00;

	typedef logic [SMP_W-1:0] sample_t;
	typedef logic [LANE_W-1:0] lane_word_t;
	typedef sample_t [3:0] lane_smp_t;

	typedef enum logic [1:0] {PART_QUAD = 2'b00, PART_DUAL = 2'b01, PART_SINGLE = 2'b10} part_kind_t;
	typedef enum logic [2:0] {SW_8 = 3'b001, SW_10 = 3'b010, SW_12 = 3'b100} sample_width_t;
	typedef enum logic [1:0] {ST_UNCONF = 2'b01, ST_ACTIVE = 2'b10} cfg_state_t;

	// Samples indexed [channel][sample], channel 0 is A
	typedef struct packed {
		sample_t [NUM_CH-1:0][SMP_PER_CH-1:0] smp;
	} frame_in_t;

	typedef struct packed {
		logic [3:0] mode;
		part_kind_t part;
	} link_cfg_t;

	typedef struct packed {
		lane_word_t [NUM_LANES-1:0] lane;
		logic [NUM_LANES-1:0] mask;
		logic [2:0] octets;
		logic valid;
	} lane_out_t;

	// Octet k of a lane frame, octet 0 sent first
	function automatic logic [7:0] lane_octet(lane_word_t w, int k);
		return w[LANE_W-1-OCT_W*k -: OCT_W];
	endfunction

	// Ones over the octets that belong to the frame
	function automatic lane_word_t keep_mask(logic [2:0] octets);
		return ~({LANE_W{1'b1}} >> (OCT_W * int'(octets)));
	endfunction

endpackage

// ---- link_mode_decode.sv ----
`timescale 1ns/10ps
module link_mode_decode
	import adc_map_pkg::*;
(
	input wire link_cfg_t i_cfg,
	output logic [NUM_LANES-1:0] o_mask,
	output logic [2:0] o_octets,
	output sample_width_t o_width,
	output logic o_legal
);

	// Pick lane count by part size from a quad/dual/single triple
	function automatic logic [7:0] by_part(part_kind_t p, logic [7:0] q, logic [7:0] d, logic [7:0] s);
		unique case (p)
			PART_QUAD: return q;
			PART_DUAL: return d;
			PART_SINGLE: return s;
			default: return LANES_0;
		endcase
	endfunction

	// Geometry of each supported mode; others leave every lane dark
	always_comb begin
		o_mask = LANES_0;
		o_octets = OCT_1;
		o_width = SW_8;
		o_legal = 1'b1;
		unique case (i_cfg.mode)
			MODE_2, MODE_7: begin
				o_mask = by_part(i_cfg.part, LANES_4, LANES_2, LANES_1);
			end
			MODE_3: begin
				o_mask = by_part(i_cfg.part, LANES_4, LANES_2, LANES_1);
				o_octets = OCT_5;
				o_width = SW_10;
			end
			MODE_4: begin
				o_mask = by_part(i_cfg.part, LANES_3, LANES_2, LANES_1);
				o_octets = OCT_2;
				o_width = SW_12;
			end
			MODE_5: begin
				o_mask = by_part(i_cfg.part, LANES_2, LANES_1, LANES_1);
				o_octets = OCT_2;
			end
			MODE_6: begin
				o_mask = by_part(i_cfg.part, LANES_6, LANES_3, LANES_2);
				o_octets = OCT_2;
				o_width = SW_12;
			end
			MODE_8: begin
				o_mask = by_part(i_cfg.part, LANES_4, LANES_2, LANES_1);
				o_octets = OCT_3;
				o_width = SW_12;
			end
			MODE_9: begin
				o_mask = by_part(i_cfg.part, LANES_8, LANES_4, LANES_2);
			end
			MODE_10: begin
				o_mask = by_part(i_cfg.part, LANES_8, LANES_4, LANES_2);
				o_octets = OCT_5;
				o_width = SW_10;
			end
			default: begin
				o_legal = 1'b0;
			end
		endcase
	end

endmodule

// ---- lane_frame_pack.sv ----
`timescale 1ns/10ps
module lane_frame_pack
	import adc_map_pkg::*;
(
	input wire lane_smp_t i_smp,
	input wire sample_width_t i_width,
	output lane_word_t o_word
);

	// Samples go back to back, MSB first, left justified; unused slots arrive as zero
	always_comb begin
		o_word = '0;
		unique case (i_width)
			SW_8: o_word = {i_smp[0][W8-1:0], i_smp[1][W8-1:0], i_smp[2][W8-1:0], i_smp[3][W8-1:0], PAD_OCTET};
			SW_10: o_word = {i_smp[0][W10-1:0], i_smp[1][W10-1:0], i_smp[2][W10-1:0], i_smp[3][W10-1:0]};
			SW_12: o_word = {i_smp[0], i_smp[1], i_smp[2], i_smp[3][SMP_W-1:SMP_W-NIB_W]};
			default: o_word = '0;
		endcase
	end

endmodule

// ---- adc_lane_sample_mapper.sv ----
`timescale 1ns/10ps
// What this block does
// - Mode 2 puts one 8-bit sample 0 per channel in a one-octet frame, A to D on lanes 0 to 3.
// - Mode 3 puts samples 0 to 3 of one channel, 10 bits each, into a five-octet frame per lane.
// - Mode 4 packs A0, B0, C0, D0 of 12 bits back to back over two-octet frames, a single part padding 0x0 after A0.
// - Mode 5 puts A0 then B0 on lane 0 and C0 then D0 on lane 1, a single part sending 0x00 for B0.
// - Mode 6 packs A0, A1, B0, B1 then C0, C1, D0, D1 as 12-bit samples over two-octet frames on up to six lanes.
// - In mode 6 a single part sends 0x00 where B0[11:4] would sit on lane 1.
// - Mode 7 puts one 8-bit sample 0 per channel in a one-octet frame, A to D on lanes 0 to 3.
// - Mode 8 puts samples 0 and 1 of one channel, 12 bits each, into a three-octet frame per lane.
// - Mode 9 uses two lanes per channel, sample 0 on the first and sample 1 on the second, one octet each.
// - Mode 10 uses two lanes per channel, even samples 0 to 6 on the first and odd 1 to 7 on the second.
// - Lanes for channel B exist only on dual and quad parts, for C and D only on quad parts.
// - Every sample is sent most significant bit first.
// - Tail bits of a frame are zero.
// - Letter and index name the channel and the sample number within the frame.
module adc_lane_sample_mapper
	import adc_map_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cfg_load,
	input wire logic [3:0] i_link_mode_select,
	input wire part_kind_t i_part_kind,
	input wire logic i_frame_valid,
	input wire frame_in_t i_frame,
	output lane_word_t [NUM_LANES-1:0] o_lane_data,
	output logic [NUM_LANES-1:0] o_lane_mask,
	output logic [2:0] o_frame_octets,
	output logic o_lane_valid,
	output logic o_mode_illegal,
	output logic o_configured
);

	typedef struct packed {
		cfg_state_t st;
		link_cfg_t cfg;
		logic configured;
		logic illegal;
		logic [3:0] out_mode;
		part_kind_t out_part;
		lane_out_t out;
	} state_t;

	state_t st_q;
	state_t st_d;
	frame_in_t frame_m;
	lane_smp_t [NUM_LANES-1:0] lane_smp;
	lane_word_t [NUM_LANES-1:0] lane_pk;
	logic [NUM_LANES-1:0] dec_mask;
	logic [2:0] dec_octets;
	sample_width_t dec_width;
	logic dec_legal;

	// True when the part in use carries this channel
	function automatic logic ch_present(part_kind_t p, int ch);
		unique case (p)
			PART_QUAD: return 1'b1;
			PART_DUAL: return ch < 2;
			PART_SINGLE: return ch == 0;
			default: return 1'b0;
		endcase
	endfunction

	// Sample set for one lane in the per-lane modes; slots beyond the frame stay zero
	function automatic lane_smp_t pick_samples(frame_in_t f, logic [3:0] mode, int l);
		lane_smp_t s;
		s = '0;
		if (mode == MODE_9 || mode == MODE_10) begin
			// Lane pair per channel; odd lane takes the odd samples
			s[0] = f.smp[l/2][l%2];
			if (mode == MODE_10) begin
				s[1] = f.smp[l/2][l%2+2];
				s[2] = f.smp[l/2][l%2+4];
				s[3] = f.smp[l/2][l%2+6];
			end
		end else if (l < NUM_CH) begin
			s[0] = f.smp[l][0];
			if (mode == MODE_8 || mode == MODE_3) begin
				s[1] = f.smp[l][1];
			end
			if (mode == MODE_3) begin
				s[2] = f.smp[l][2];
				s[3] = f.smp[l][3];
			end
		end
		return s;
	endfunction

	link_mode_decode u_decode (
		.i_cfg(st_q.cfg),
		.o_mask(dec_mask),
		.o_octets(dec_octets),
		.o_width(dec_width),
		.o_legal(dec_legal)
	);

	// Absent channels become zeros so padding falls out of the same packing
	always_comb begin
		frame_m = i_frame;
		for (int c = 0; c < NUM_CH; c++) begin
			if (!ch_present(st_q.cfg.part, c)) begin
				frame_m.smp[c] = '0;
			end
		end
	end

	// One packer per lane for the modes where a lane holds only its own samples
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		assign lane_smp[l] = pick_samples(frame_m, st_q.cfg.mode, l);
		lane_frame_pack u_pack (
			.i_smp(lane_smp[l]),
			.i_width(dec_width),
			.o_word(lane_pk[l])
		);
	end

	// Next state: the frame mapped with the configuration already held, then any new configuration
	always_comb begin
		logic [4*SMP_W-1:0] s48;
		logic [8*SMP_W-1:0] s96;
		lane_word_t [NUM_LANES-1:0] lw;
		st_d = st_q;
		s48 = {frame_m.smp[0][0], frame_m.smp[1][0], frame_m.smp[2][0], frame_m.smp[3][0]};
		s96 = {frame_m.smp[0][0], frame_m.smp[0][1], frame_m.smp[1][0], frame_m.smp[1][1],
			frame_m.smp[2][0], frame_m.smp[2][1], frame_m.smp[3][0], frame_m.smp[3][1]};
		lw = lane_pk;
		unique case (st_q.cfg.mode)
			MODE_4: begin
				// Twelve-bit samples run across lane borders
				for (int l = 0; l < 3; l++) begin
					lw[l] = {s48[4*SMP_W-1-2*OCT_W*l -: 2*OCT_W], {(LANE_W-2*OCT_W){1'b0}}};
				end
			end
			MODE_5: begin
				lw[0] = {frame_m.smp[0][0][W8-1:0], frame_m.smp[1][0][W8-1:0], {(LANE_W-2*OCT_W){1'b0}}};
				lw[1] = {frame_m.smp[2][0][W8-1:0], frame_m.smp[3][0][W8-1:0], {(LANE_W-2*OCT_W){1'b0}}};
			end
			MODE_6: begin
				for (int l = 0; l < 6; l++) begin
					lw[l] = {s96[8*SMP_W-1-2*OCT_W*l -: 2*OCT_W], {(LANE_W-2*OCT_W){1'b0}}};
				end
			end
			default: begin
				lw = lane_pk;
			end
		endcase
		// Tail octets and lanes the part lacks are forced to zero
		for (int l = 0; l < NUM_LANES; l++) begin
			lw[l] = dec_mask[l] ? (lw[l] & keep_mask(dec_octets)) : '0;
		end
		st_d.out.valid = 1'b0;
		if (i_frame_valid && st_q.st == ST_ACTIVE && dec_legal) begin
			st_d.out.valid = 1'b1;
			st_d.out.lane = lw;
			st_d.out.mask = dec_mask;
			st_d.out.octets = dec_octets;
			st_d.out_mode = st_q.cfg.mode;
			st_d.out_part = st_q.cfg.part;
		end
		st_d.illegal = !dec_legal;
		// New setting applies from the next frame on
		if (i_cfg_load) begin
			st_d.cfg.mode = i_link_mode_select;
			st_d.cfg.part = i_part_kind;
			st_d.st = ST_ACTIVE;
			st_d.configured = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q.st <= ST_UNCONF;
			st_q.cfg.mode <= MODE_RST;
			st_q.cfg.part <= PART_QUAD;
			st_q.illegal <= 1'b0;
			st_q.configured <= 1'b0;
			st_q.out_mode <= MODE_RST;
			st_q.out_part <= PART_QUAD;
			st_q.out <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign o_lane_data = st_q.out.lane;
	assign o_lane_mask = st_q.out.mask;
	assign o_frame_octets = st_q.out.octets;
	assign o_lane_valid = st_q.out.valid;
	assign o_mode_illegal = st_q.illegal;
	assign o_configured = st_q.configured; // Own flop, so no gate sits behind the pin

	// Checks: any dark lane or tail octet holding data
	logic tail_dirty;
	logic dark_dirty;
	always_comb begin
		tail_dirty = 1'b0;
		dark_dirty = 1'b0;
		for (int l = 0; l < NUM_LANES; l++) begin
			if ((o_lane_data[l] & ~keep_mask(o_frame_octets)) != '0) begin
				tail_dirty = 1'b1;
			end
			if (!o_lane_mask[l] && o_lane_data[l] != '0) begin
				dark_dirty = 1'b1;
			end
		end
	end

	frame_latency_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_frame_valid && o_configured && !i_cfg_load && dec_legal) ##1 1'b1 |-> o_lane_valid && o_lane_mask == $past(dec_mask))
		else $error("accepted frame not presented one cycle later");

	tail_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid |-> !tail_dirty)
		else $error("tail octets not zero");

	absent_lanes_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_part == PART_SINGLE && st_q.out_mode == MODE_2 |-> o_lane_mask == LANES_1 && !dark_dirty)
		else $error("single part drives extra lanes");

	mode2_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_2 && st_q.out_part == PART_QUAD
		|-> lane_octet(o_lane_data[3], 0) == $past(i_frame.smp[3][0][W8-1:0]))
		else $error("mode 2 lane 3 not D0");

	mode3_msb_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_3
		|-> o_lane_data[0] == {$past(i_frame.smp[0][0][W10-1:0]), $past(i_frame.smp[0][1][W10-1:0]),
			$past(i_frame.smp[0][2][W10-1:0]), $past(i_frame.smp[0][3][W10-1:0])})
		else $error("mode 3 lane 0 packing wrong");

	mode4_pad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_4 && st_q.out_part == PART_SINGLE
		|-> o_lane_data[0][LANE_W-1 -: 2*OCT_W] == {$past(i_frame.smp[0][0]), PAD_NIBBLE})
		else $error("mode 4 single pad wrong");

	mode5_pad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_5 && st_q.out_part == PART_SINGLE
		|-> lane_octet(o_lane_data[0], 1) == PAD_OCTET && o_lane_mask == LANES_1)
		else $error("mode 5 single pad wrong");

	mode6_pad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_6 && st_q.out_part == PART_SINGLE
		|-> lane_octet(o_lane_data[1], 1) == PAD_OCTET && lane_octet(o_lane_data[1], 0) == $past(i_frame.smp[0][1][W8-1:0]))
		else $error("mode 6 single pad wrong");

	mode6_split_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_6 && st_q.out_part == PART_QUAD
		|-> o_lane_data[2][LANE_W-1 -: 2*OCT_W] == {$past(i_frame.smp[1][0][NIB_W-1:0]), $past(i_frame.smp[1][1])})
		else $error("mode 6 lane 2 wrong");

	mode8_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_8 && st_q.out_part != PART_SINGLE
		|-> o_lane_data[1][LANE_W-1 -: 3*OCT_W] == {$past(i_frame.smp[1][0]), $past(i_frame.smp[1][1])})
		else $error("mode 8 lane 1 wrong");

	mode9_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_9
		|-> lane_octet(o_lane_data[1], 0) == $past(i_frame.smp[0][1][W8-1:0]))
		else $error("mode 9 second lane not sample 1");

	mode10_odd_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_10
		|-> o_lane_data[1] == {$past(i_frame.smp[0][1][W10-1:0]), $past(i_frame.smp[0][3][W10-1:0]),
			$past(i_frame.smp[0][5][W10-1:0]), $past(i_frame.smp[0][7][W10-1:0])})
		else $error("mode 10 odd lane wrong");

	mode7_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_7 && st_q.out_part != PART_SINGLE
		|-> lane_octet(o_lane_data[1], 0) == $past(i_frame.smp[1][0][W8-1:0]) && o_frame_octets == OCT_1)
		else $error("mode 7 lane 1 not B0");

	illegal_dark_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_mode_illegal |-> !o_lane_valid)
		else $error("frame sent under unsupported mode");

	unconf_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_configured |-> !o_lane_valid)
		else $error("frame sent before any setting");

	config_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_cfg_load |=> $stable(st_q.cfg))
		else $error("setting changed without a load");

	mode4_quad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_4 && st_q.out_part == PART_QUAD
		|-> o_lane_data[2][LANE_W-1 -: 2*OCT_W] == {$past(i_frame.smp[2][0][NIB_W-1:0]), $past(i_frame.smp[3][0])})
		else $error("mode 4 lane 2 wrong");

	mode5_quad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_5 && st_q.out_part == PART_QUAD
		|-> lane_octet(o_lane_data[1], 0) == $past(i_frame.smp[2][0][W8-1:0])
			&& lane_octet(o_lane_data[1], 1) == $past(i_frame.smp[3][0][W8-1:0]))
		else $error("mode 5 lane 1 not C0 D0");

	mode9_quad_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_mode == MODE_9 && st_q.out_part == PART_QUAD
		|-> lane_octet(o_lane_data[7], 0) == $past(i_frame.smp[3][1][W8-1:0]))
		else $error("mode 9 last lane not D1");

	dual_lanes_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lane_valid && st_q.out_part == PART_DUAL
		|-> o_lane_mask[NUM_LANES-1:NUM_LANES/2] == '0 && !dark_dirty)
		else $error("dual part drives upper lanes");

endmodule

// ---- lane_rx_model.sv ----
`timescale 1ns/10ps
// Far-end receiver: takes each mapped frame, keeping only the lanes the part really has
module lane_rx_model
	import adc_map_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire lane_word_t [NUM_LANES-1:0] i_lane_data,
	input wire logic [NUM_LANES-1:0] i_lane_mask,
	input wire logic i_lane_valid,
	output int o_frames,
	output lane_word_t [NUM_LANES-1:0] o_rx_lanes
);
	// No back-pressure exists, so the receiver must keep up with every valid cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_frames <= 0;
			o_rx_lanes <= '0;
		end else if (i_lane_valid) begin
			o_frames <= o_frames + 1;
			for (int l = 0; l < NUM_LANES; l++) begin
				o_rx_lanes[l] <= i_lane_mask[l] ? i_lane_data[l] : '0;
			end
		end
	end
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import adc_map_pkg::*;
	logic i_clk;
	logic i_rst;
	logic i_cfg_load;
	logic [3:0] i_link_mode_select;
	part_kind_t i_part_kind;
	logic i_frame_valid;
	frame_in_t i_frame;
	lane_word_t [NUM_LANES-1:0] o_lane_data;
	logic [NUM_LANES-1:0] o_lane_mask;
	logic [2:0] o_frame_octets;
	logic o_lane_valid;
	logic o_mode_illegal;
	logic o_configured;
	int rx_frames;
	lane_word_t [NUM_LANES-1:0] rx_lanes;
	lane_out_t last_exp;
	int bad_count;
	int n_tests;
	int exp_frames;
	integer seed;
	lane_out_t exp_q[$];

	adc_lane_sample_mapper dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_load(i_cfg_load),
		.i_link_mode_select(i_link_mode_select), .i_part_kind(i_part_kind), .i_frame_valid(i_frame_valid),
		.i_frame(i_frame), .o_lane_data(o_lane_data), .o_lane_mask(o_lane_mask),
		.o_frame_octets(o_frame_octets), .o_lane_valid(o_lane_valid), .o_mode_illegal(o_mode_illegal),
		.o_configured(o_configured));

	lane_rx_model rx_u (.i_clk(i_clk), .i_rst(i_rst), .i_lane_data(o_lane_data), .i_lane_mask(o_lane_mask),
		.i_lane_valid(o_lane_valid), .o_frames(rx_frames), .o_rx_lanes(rx_lanes));

	// Clock at 40 MHz
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic int swidth(input int mode);
		case (mode)
			3, 10: return 10;
			4, 6, 8: return 12;
			default: return 8;
		endcase
	endfunction

	// Reference: every mode is one MSB-first bit stream cut into equal lane frames
	function automatic lane_out_t model(input int mode, input int part, input frame_in_t fr);
		lane_out_t r;
		int w, k, lb, nch, p, idx;
		r = '0;
		w = swidth(mode);
		case (mode)
			2, 7: begin k = 1; lb = 8; end
			3: begin k = 4; lb = 40; end
			4, 5: begin k = 1; lb = 16; end
			6: begin k = 2; lb = 16; end
			8: begin k = 2; lb = 24; end
			9: begin k = 2; lb = 8; end
			default: begin k = 8; lb = 40; end
		endcase
		// Part code 3 carries no channel at all
		nch = (part == 0) ? 4 : (part == 1) ? 2 : (part == 2) ? 1 : 0;
		p = 0;
		for (int c = 0; c < nch; c++) begin
			for (int j = 0; j < k; j++) begin
				// Mode 10 sends the even samples on the first lane of the pair
				idx = (mode == 10) ? ((j < 4) ? 2 * j : 2 * j - 7) : j;
				for (int b = w - 1; b >= 0; b--) begin
					r.lane[p / lb][LANE_W - 1 - p % lb] = fr.smp[c][idx][b];
					p++;
				end
			end
		end
		for (int l = 0; l < (p + lb - 1) / lb; l++) begin
			r.mask[l] = 1'b1;
		end
		r.octets = 3'(lb / 8);
		r.valid = 1'b1;
		return r;
	endfunction

	// Load a setting, then send back-to-back frames under it
	task automatic run_cfg(input int mode, input int part, input int nfr);
		frame_in_t fr;
		logic legal;
		legal = (mode >= 2 && mode <= 10);
		@(posedge i_clk);
		i_cfg_load <= 1'b1;
		i_link_mode_select <= 4'(mode);
		i_part_kind <= part_kind_t'(part);
		@(posedge i_clk);
		i_cfg_load <= 1'b0;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		check("configured", o_configured, 1'b1);
		check("illegal", o_mode_illegal, !legal);
		for (int f = 0; f < nfr; f++) begin
			@(posedge i_clk);
			for (int c = 0; c < NUM_CH; c++) begin
				for (int n = 0; n < SMP_PER_CH; n++) begin
					fr.smp[c][n] = 12'($random(seed)) & (12'h0fff >> (12 - swidth(legal ? mode : 2)));
				end
			end
			i_frame_valid <= 1'b1;
			i_frame <= fr;
			if (legal) begin
				exp_q.push_back(model(mode, part, fr));
				exp_frames++;
			end
		end
		@(posedge i_clk);
		i_frame_valid <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask

	// Every output frame is matched against the reference in order
	always @(negedge i_clk) begin
		lane_out_t e;
		if (i_rst === 1'b0 && o_lane_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected frame", o_lane_valid, 1'b0);
			end else begin
				e = exp_q.pop_front();
				last_exp = e;
				for (int l = 0; l < NUM_LANES; l++) begin
					check($sformatf("lane %0d", l), o_lane_data[l], e.lane[l]);
				end
				check("mask", o_lane_mask, e.mask);
				check("octets", o_frame_octets, e.octets);
			end
		end
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		$display("BAD timeout expected done seen hang");
		complete_run();
	end

	initial begin
		seed = 32'hd404;
		bad_count = 0;
		n_tests = 0;
		exp_frames = 0;
		i_rst = 1'b1;
		i_cfg_load = 1'b0;
		i_link_mode_select = 4'h0;
		i_part_kind = PART_QUAD;
		i_frame_valid = 1'b0;
		i_frame = '0;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		// Frames before any setting is loaded are dropped
		@(posedge i_clk);
		i_frame_valid <= 1'b1;
		@(posedge i_clk);
		i_frame_valid <= 1'b0;
		@(negedge i_clk);
		check("configured at start", o_configured, 1'b0);
		run_cfg(2, 3, 2);
		for (int m = 2; m <= 10; m++) begin
			for (int p = 0; p < 3; p++) begin
				run_cfg(m, p, 3);
			end
		end
		run_cfg(0, 0, 2);
		run_cfg(1, 0, 2);
		run_cfg(11, 0, 2);
		run_cfg(15, 0, 2);
		for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge i_clk);
		check("pending frames", 40'(exp_q.size()), 40'h0);
		check("frames at receiver", 40'(rx_frames), 40'(exp_frames));
		// Receiver holds the last frame, lanes the part lacks as zero
		for (int l = 0; l < NUM_LANES; l++) begin
			check("rx lane", rx_lanes[l], last_exp.lane[l]);
		end
		// Reset in mid-run clears the setting and the outputs
		@(posedge i_clk);
		i_rst <= 1'b1;
		@(negedge i_clk);
		check("configured in reset", o_configured, 1'b0);
		check("mask in reset", o_lane_mask, 8'h00);
		check("valid in reset", o_lane_valid, 1'b0);
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		run_cfg(6, 2, 2);
		for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge i_clk);
		check("pending after reset", 40'(exp_q.size()), 40'h0);
		complete_run();
	end
endmodule
